// File: design/can_cfg_device.sv
/*
 * can controller configuration end: control-area words reached through
 * the data pointer and data buffer, bit timing sequencer with resync and
 * triple sampling, and the identifier / media acceptance test.
 * assumes the host end loads the pointer before each buffer transfer and
 * the receive pin arrives asynchronously.
 */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - media test compares data bytes 0,1
// - media test off ignores media arbitration
// - writes only while software init set
// - resync step limited to code+1 quanta
// - prescale code plus one sets quantum
// - one sample or three with majority
// - triple sampling adds two clocks to seg1
// - no triple sampling below prescale four
// - phase2 is code plus one, zero invalid
// - phase1 is code plus one, zero invalid
// - standard mask for standard centres only
// - masking off needs exact identifier match
// - mask zero ignores, one requires equality
// - low five std mask bits unused
// - extended mask compares 29 bits
// - low three extended mask bits unused
// - zero global mask accepts everything
// - centre 15 uses own mask, 29/11
// - low three centre15 mask bits unused
// - zero centre15 mask accepts everything
// - byte compares under media mask bits
// - access only via pointer and buffer
module can_cfg_device
   import can_cfg_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   can_cfg_if.dev           link,
   input  wire logic        rx_pin,
   output logic             bit_value_q,
   output logic             bit_strobe_q,
   input  wire logic        cand_valid,
   input  wire logic        cand_last_centre,
   input  wire logic        cand_ext,
   input  wire logic        cand_mask_en,
   input  wire logic        cand_media_en,
   input  wire logic [28:0] cand_arb,
   input  wire logic        rx_ext,
   input  wire logic [28:0] rx_id,
   input  wire logic [7:0]  rx_byte0,
   input  wire logic [7:0]  rx_byte1,
   output logic             accept_q,
   output logic             accept_valid_q
);
   // bits of a word that store data
   function automatic logic [15:0] used_bits(input logic [2:0] idx);
      unique case (idx)
         W_STD_MASK: used_bits = STD_MASK_USED;
         W_EXT_LO:   used_bits = LOW29_USED;
         W_LAST_LO:  used_bits = LOW29_USED;
         default:    used_bits = FULL_USED;
      endcase
   endfunction : used_bits

   logic [15:0]     word_q [NUM_WORDS];
   logic [PTR_W-1:0] ptr_q;
   logic            in_ctrl;
   logic [15:0]     rdata_q;
   logic            rvalid_q;

   assign in_ctrl = (ptr_q[PTR_W-1:3] == '0);

   // data pointer
   always_ff @(posedge clock) begin
      if (rst) begin
         ptr_q <= '0;
      end else if (ce && link.ptr_load) begin
         ptr_q <= link.ptr_value;
      end
   end

   // control words, writable only during software init
   generate
      for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
         always_ff @(posedge clock) begin
            if (rst) begin
               word_q[i] <= WORD_RESET;
            end else if (ce && link.buf_write && link.software_init && in_ctrl
                         && ptr_q[2:0] == 3'(i)) begin
               word_q[i] <= link.wdata & used_bits(3'(i));
            end
         end
      end
   endgenerate

   // buffer reads, always permitted; outside the area reads zero
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
      end else if (ce) begin
         rvalid_q <= link.buf_read;
         if (link.buf_read) begin
            rdata_q <= in_ctrl ? word_q[ptr_q[2:0]] : 16'h0000;
         end
      end
   end
   assign link.rdata  = rdata_q;
   assign link.rvalid = rvalid_q;

   // timing fields
   logic [7:0] presc_code;
   logic [5:0] ph1_len;
   logic [3:0] ph2_len;
   logic [2:0] rjw;
   logic       triple;
   assign presc_code = {link.prescale_hi, word_q[W_TIMING][PRESCALE_LSB +: 6]};
   assign ph1_len    = 6'(word_q[W_TIMING][PH1_LSB +: 4]) + 6'h01;
   assign ph2_len    = 4'(word_q[W_TIMING][PH2_LSB +: 3]) + 4'h1;
   assign rjw        = 3'(word_q[W_TIMING][RJW_LSB +: 2]) + 3'h1;
   assign triple     = word_q[W_TIMING][TRIPLE_BIT];

   // receive pin synchroniser
   logic rx_m_q, rx_s_q, rx_prev_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_m_q    <= 1'b1;
         rx_s_q    <= 1'b1;
         rx_prev_q <= 1'b1;
      end else if (ce) begin
         rx_m_q    <= rx_pin;
         rx_s_q    <= rx_m_q;
         rx_prev_q <= rx_s_q;
      end
   end

   bit_phase_t phase_q;
   logic [7:0] tq_cnt_q;
   logic       tq_tick;
   logic       falling;
   assign tq_tick = (tq_cnt_q == presc_code);
   assign falling = rx_prev_q && !rx_s_q;

   // quantum prescaler, held during the triple-sample extension
   always_ff @(posedge clock) begin
      if (rst) begin
         tq_cnt_q <= 8'h00;
      end else if (ce) begin
         if (phase_q == PH_EXTRA || tq_tick) begin
            tq_cnt_q <= 8'h00;
         end else begin
            tq_cnt_q <= tq_cnt_q + 8'h01;
         end
      end
   end

   logic [5:0] qcnt_q;
   logic [5:0] seg1_lim_q;
   logic [3:0] seg2_lim_q;
   logic       resynced_q;
   logic [1:0] extra_q;
   logic [2:0] smp_q;
   logic [5:0] err;
   logic [3:0] remain;
   assign err    = (qcnt_q + 6'h01 < 6'(rjw)) ? qcnt_q + 6'h01 : 6'(rjw);
   assign remain = seg2_lim_q - qcnt_q[3:0];

   // bit sequencer: sync quantum, phase 1, optional extension, phase 2
   always_ff @(posedge clock) begin
      if (rst) begin
         phase_q      <= PH_SYNC;
         qcnt_q       <= 6'h00;
         seg1_lim_q   <= 6'h01;
         seg2_lim_q   <= 4'h1;
         resynced_q   <= 1'b0;
         extra_q      <= 2'h0;
         smp_q        <= 3'h0;
         bit_value_q  <= 1'b1;
         bit_strobe_q <= 1'b0;
      end else if (ce) begin
         bit_strobe_q <= 1'b0;
         unique case (phase_q)
            PH_SYNC: begin
               resynced_q <= 1'b0;
               if (tq_tick) begin
                  phase_q    <= PH_SEG1;
                  qcnt_q     <= 6'h00;
                  seg1_lim_q <= ph1_len;
                  seg2_lim_q <= ph2_len;
               end
            end
            PH_SEG1: begin
               if (falling && !resynced_q) begin
                  seg1_lim_q <= seg1_lim_q + err;
                  resynced_q <= 1'b1;
               end else if (tq_tick) begin
                  if (qcnt_q + 6'h01 >= seg1_lim_q) begin
                     qcnt_q   <= 6'h00;
                     smp_q[0] <= rx_s_q;
                     if (triple) begin
                        phase_q <= PH_EXTRA;
                        extra_q <= 2'h0;
                     end else begin
                        phase_q      <= PH_SEG2;
                        bit_value_q  <= rx_s_q;
                        bit_strobe_q <= 1'b1;
                     end
                  end else begin
                     qcnt_q <= qcnt_q + 6'h01;
                  end
               end
            end
            PH_EXTRA: begin
               smp_q[extra_q + 2'h1] <= rx_s_q;
               extra_q <= extra_q + 2'h1;
               if (extra_q == 2'(TRIPLE_EXTRA_CYCLES - 1)) begin
                  phase_q      <= PH_SEG2;
                  bit_strobe_q <= 1'b1;
                  bit_value_q  <= (smp_q[0] & smp_q[1]) | (smp_q[0] & rx_s_q)
                                  | (smp_q[1] & rx_s_q);
               end
            end
            PH_SEG2: begin
               if (falling && !resynced_q) begin
                  resynced_q <= 1'b1;
                  if (remain <= 4'(rjw)) begin
                     phase_q    <= PH_SEG1;  // edge ends the bit early
                     qcnt_q     <= 6'h00;
                     seg1_lim_q <= ph1_len;
                     seg2_lim_q <= ph2_len;
                  end else begin
                     seg2_lim_q <= seg2_lim_q - 4'(rjw);
                  end
               end else if (tq_tick) begin
                  if (qcnt_q[3:0] + 4'h1 >= seg2_lim_q) begin
                     phase_q <= PH_SYNC;
                     qcnt_q  <= 6'h00;
                  end else begin
                     qcnt_q <= qcnt_q + 6'h01;
                  end
               end
            end
         endcase
      end
   end

   // acceptance masks
   logic [10:0] std_mask;
   logic [28:0] ext_mask, last_mask, mask29, diff;
   logic        id_ok, media_ok;
   assign std_mask  = {word_q[W_STD_MASK][7:0], word_q[W_STD_MASK][15:13]};
   assign ext_mask  = {word_q[W_EXT_HI][7:0], word_q[W_EXT_HI][15:8],
                       word_q[W_EXT_LO][7:0], word_q[W_EXT_LO][15:11]};
   assign last_mask = {word_q[W_LAST_HI][7:0], word_q[W_LAST_HI][15:8],
                       word_q[W_LAST_LO][7:0], word_q[W_LAST_LO][15:11]};
   assign diff      = rx_id ^ cand_arb;

   // identifier and media tests, one verdict per candidate
   always_comb begin
      if (!cand_mask_en) begin
         mask29 = '1;
      end else if (cand_last_centre) begin
         mask29 = last_mask;
      end else if (cand_ext) begin
         mask29 = ext_mask;
      end else begin
         mask29 = {std_mask, 18'h00000};
      end
      if (cand_ext) begin
         id_ok = ((diff & mask29) == '0);
      end else begin
         id_ok = ((diff[28:18] & mask29[28:18]) == '0);
      end
      media_ok = !cand_media_en
                 || ((((rx_byte0 ^ word_q[W_MEDIA0][15:8]) & word_q[W_MEDIA0][7:0]) == 8'h00)
                 && (((rx_byte1 ^ word_q[W_MEDIA1][15:8]) & word_q[W_MEDIA1][7:0]) == 8'h00));
   end

   // registered verdict
   always_ff @(posedge clock) begin
      if (rst) begin
         accept_q       <= 1'b0;
         accept_valid_q <= 1'b0;
      end else if (ce) begin
         accept_valid_q <= cand_valid;
         if (cand_valid) begin
            accept_q <= (cand_ext == rx_ext) && id_ok && media_ok;
         end
      end
   end
endmodule : can_cfg_device
`default_nettype wire

// File: design/can_cfg_pkg.sv
/*
 * constants shared by both ends of the can configuration link:
 * control-area word indices, field positions, reset values, timing counts.
 * assumes a single 20 MHz clock domain for both ends.
 */
package can_cfg_pkg;
   // clock figure
   localparam int           CLOCK_PERIOD_NS = 50;
   // control area: eight 16-bit words, low byte (L) and high byte (H)
   localparam int           NUM_WORDS       = 8;
   localparam int           PTR_W           = 7;
   localparam logic [2:0]   W_MEDIA0        = 3'h0;  // L: media mask 0, H: media_arb_byte0
   localparam logic [2:0]   W_MEDIA1        = 3'h1;  // L: media mask 1, H: media_arb_byte1
   localparam logic [2:0]   W_TIMING        = 3'h2;  // L: prescale/sjw, H: segments
   localparam logic [2:0]   W_STD_MASK      = 3'h3;  // std_global_mask_hi / _lo
   localparam logic [2:0]   W_EXT_HI        = 3'h4;  // ext_global_mask_b0 / _b1
   localparam logic [2:0]   W_EXT_LO        = 3'h5;  // ext_global_mask_b2 / _b3
   localparam logic [2:0]   W_LAST_HI       = 3'h6;  // last_centre_mask_b0 / _b1
   localparam logic [2:0]   W_LAST_LO       = 3'h7;  // last_centre_mask_b2 / _b3
   localparam logic [15:0]  WORD_RESET      = 16'h0000;
   // bits that hold data; the rest read zero and ignore writes
   localparam logic [15:0]  STD_MASK_USED   = 16'hE0FF;
   localparam logic [15:0]  LOW29_USED      = 16'hF8FF;
   localparam logic [15:0]  FULL_USED       = 16'hFFFF;
   // timing word field positions
   localparam int           PRESCALE_LSB    = 0;
   localparam int           RJW_LSB         = 6;
   localparam int           PH1_LSB         = 8;
   localparam int           PH2_LSB         = 12;
   localparam int           TRIPLE_BIT      = 15;
   // timing counts
   localparam int           TRIPLE_EXTRA_CYCLES = 2;
   localparam logic [7:0]   TRIPLE_MIN_CODE     = 8'h03;  // prescale value 4
   // states of the bit timing sequencer
   typedef enum logic [1:0] {PH_SYNC, PH_SEG1, PH_EXTRA, PH_SEG2} bit_phase_t;
   // states of the host transfer sequencer
   typedef enum logic [1:0] {HS_IDLE, HS_PTR, HS_XFER, HS_WAIT} host_state_t;
endpackage : can_cfg_pkg

// File: design/can_cfg_if.sv
/*
 * link between the host cpu end and the can controller end:
 * data pointer load, data buffer transfer, init bit and high prescale bits.
 * assumes both ends share one clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface can_cfg_if;
   logic        ptr_load;       // load can_data_pointer
   logic [6:0]  ptr_value;      // dual-port word address
   logic        buf_write;      // write through can_data_buffer
   logic        buf_read;       // read through can_data_buffer
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rvalid;         // read data valid, one cycle
   logic        software_init;  // software_init_bit of can_operation_register
   logic [1:0]  prescale_hi;    // prescale code bits 7:6
   modport dev  (input ptr_load, ptr_value, buf_write, buf_read, wdata, software_init,
                 prescale_hi, output rdata, rvalid);
   modport host (output ptr_load, ptr_value, buf_write, buf_read, wdata, software_init,
                 prescale_hi, input rdata, rvalid);
endinterface : can_cfg_if
`default_nettype wire

// File: design/can_cfg_host.sv
/*
 * host cpu end: turns word read/write commands into a pointer load and a
 * buffer transfer, drives the init bit and high prescale bits, and refuses
 * writes that the controller must not see.
 * assumes the device end answers a buffer read one cycle later.
 */
`timescale 1ns/1ns
`default_nettype none
module can_cfg_host
   import can_cfg_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   can_cfg_if.host          link,
   input  wire logic        init_request,
   input  wire logic [1:0]  prescale_hi_in,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [6:0]  cmd_addr,
   input  wire logic [15:0] cmd_wdata,
   output logic             cmd_ready,
   output logic             cmd_refused_q,
   output logic             resp_valid_q,
   output logic [15:0]      resp_data_q
);
   host_state_t state_q;
   logic        write_q;
   logic [6:0]  addr_q;
   logic [15:0] wdata_q;
   logic        init_q;
   logic [1:0]  presc_hi_q;
   logic        bad_write;
   logic [7:0]  new_code;

   assign cmd_ready = (state_q == HS_IDLE);
   assign new_code  = {presc_hi_q, cmd_wdata[PRESCALE_LSB +: 6]};
   // writes the controller would drop or must not receive
   assign bad_write = cmd_write && (!init_q
                      || (cmd_addr == 7'(W_TIMING)
                          && (cmd_wdata[PH2_LSB +: 3] == 3'h0
                              || cmd_wdata[PH1_LSB +: 4] == 4'h0
                              || (cmd_wdata[TRIPLE_BIT] && new_code < TRIPLE_MIN_CODE))));

   // operation register bits
   always_ff @(posedge clock) begin
      if (rst) begin
         init_q     <= 1'b0;
         presc_hi_q <= 2'h0;
      end else if (ce) begin
         init_q <= init_request;
         if (init_q) begin
            presc_hi_q <= prescale_hi_in;
         end
      end
   end

   // transfer sequencer: pointer, then buffer
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q       <= HS_IDLE;
         write_q       <= 1'b0;
         addr_q        <= 7'h00;
         wdata_q       <= 16'h0000;
         cmd_refused_q <= 1'b0;
         resp_valid_q  <= 1'b0;
         resp_data_q   <= 16'h0000;
      end else if (ce) begin
         cmd_refused_q <= 1'b0;
         resp_valid_q  <= 1'b0;
         unique case (state_q)
            HS_IDLE: begin
               if (cmd_valid && bad_write) begin
                  cmd_refused_q <= 1'b1;
               end else if (cmd_valid) begin
                  state_q <= HS_PTR;
                  write_q <= cmd_write;
                  addr_q  <= cmd_addr;
                  wdata_q <= cmd_wdata;
               end
            end
            HS_PTR:  state_q <= HS_XFER;
            HS_XFER: state_q <= write_q ? HS_IDLE : HS_WAIT;
            HS_WAIT: begin
               if (link.rvalid) begin
                  state_q      <= HS_IDLE;
                  resp_valid_q <= 1'b1;
                  resp_data_q  <= link.rdata;
               end
            end
         endcase
      end
   end

   // link drive
   assign link.ptr_load      = ce && (state_q == HS_PTR);
   assign link.ptr_value     = addr_q;
   assign link.buf_write     = ce && (state_q == HS_XFER) && write_q;
   assign link.buf_read      = ce && (state_q == HS_XFER) && !write_q;
   assign link.wdata         = wdata_q;
   assign link.software_init = init_q;
   assign link.prescale_hi   = presc_hi_q;
endmodule : can_cfg_host
`default_nettype wire

// File: verification/can_cfg_asserts.sv
/* link checker: pointer/buffer walk, reply timing, reserved bits and timing word sanity.
   assumes one clock, synchronous active-high reset, both ends run with ce high. */
`timescale 1ns/1ns
`default_nettype none
module can_cfg_asserts (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ptr_load,
   input  wire logic [6:0]  ptr_value,
   input  wire logic        buf_write,
   input  wire logic        buf_read,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] rdata,
   input  wire logic        rvalid,
   input  wire logic        software_init,
   input  wire logic [1:0]  prescale_hi
);
   logic [6:0] ptr_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // last pointer loaded, seen by later transfers
   always_ff @(posedge clock) begin
      if (rst) ptr_q <= 7'h00;
      else if (ptr_load) ptr_q <= ptr_value;
   end
   sequence read_req;
      ptr_load ##1 buf_read;
   endsequence
   sequence timing_write;
      buf_write && ptr_q == 7'h02;
   endsequence
   rd_answer_a: assert property (read_req |=> rvalid)
      else $error("read not answered next cycle");
   no_spur_a: assert property (rvalid |-> $past(buf_read))
      else $error("read reply without request");
   wr_order_a: assert property (buf_write |-> $past(ptr_load))
      else $error("buffer write without pointer load");
   init_gate_a: assert property (buf_write |-> software_init)
      else $error("write sent while init bit low");
   hold_data_a: assert property ($changed(rdata) |-> rvalid)
      else $error("read word changed without reply");
   std_reserved_a: assert property (rvalid && ptr_q == 7'h03 |-> rdata[12:8] == 5'h00)
      else $error("standard mask unused bits not zero");
   ext_reserved_a: assert property (rvalid && ptr_q == 7'h05 |-> rdata[10:8] == 3'h0)
      else $error("extended mask unused bits not zero");
   last_reserved_a: assert property (rvalid && ptr_q == 7'h07 |-> rdata[10:8] == 3'h0)
      else $error("centre 15 mask unused bits not zero");
   far_read_a: assert property (rvalid && ptr_q > 7'h07 |-> rdata == 16'h0000)
      else $error("outside control area read not zero");
   phase2_code_a: assert property (timing_write |-> wdata[14:12] != 3'h0)
      else $error("phase 2 code zero written");
   phase1_code_a: assert property (timing_write |-> wdata[11:8] != 4'h0)
      else $error("phase 1 code zero written");
   triple_min_a: assert property ((timing_write and wdata[15]) |-> {prescale_hi, wdata[5:0]} >= 8'h03)
      else $error("triple sampling with small prescale");
endmodule : can_cfg_asserts
`default_nettype wire

// File: verification/testbench.sv
/* self-checking bench: host end and device end joined by the link interface.
   assumes the design package and interface are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench
   import can_cfg_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        init_request = 1'b0;
   logic [1:0]  pre_hi = 2'h0;
   logic        cmd_valid = 1'b0;
   logic        cmd_write = 1'b0;
   logic [6:0]  cmd_addr = 7'h00;
   logic [15:0] cmd_wdata = 16'h0000;
   logic        cmd_ready, cmd_refused_q, resp_valid_q, bit_value_q, bit_strobe_q, accept_q, accept_valid_q;
   logic [15:0] resp_data_q;
   logic        rx_pin = 1'b1;
   logic        cand_valid = 1'b0;
   logic        cand_last_centre = 1'b0;
   logic        cand_ext = 1'b0;
   logic        cand_mask_en = 1'b0;
   logic        cand_media_en = 1'b0;
   logic [28:0] cand_arb = 29'h0;
   logic        rx_ext = 1'b0;
   logic [28:0] rx_id = 29'h0;
   logic [7:0]  rx_byte0 = 8'h00;
   logic [7:0]  rx_byte1 = 8'h00;
   int          n_fail = 0;
   int          num_checks = 0;
   int          cycles = 0;
   can_cfg_if link ();
   can_cfg_host can_cfg_host_i (.clock, .rst, .ce(1'b1), .link(link), .init_request, .prescale_hi_in(pre_hi),
      .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready, .cmd_refused_q, .resp_valid_q, .resp_data_q);
   can_cfg_device can_cfg_device_i (.clock, .rst, .ce(1'b1), .link(link), .rx_pin, .bit_value_q, .bit_strobe_q,
      .cand_valid, .cand_last_centre, .cand_ext, .cand_mask_en, .cand_media_en, .cand_arb, .rx_ext, .rx_id,
      .rx_byte0, .rx_byte1, .accept_q, .accept_valid_q);
   can_cfg_asserts can_cfg_asserts_i (.clock, .rst, .ptr_load(link.ptr_load), .ptr_value(link.ptr_value),
      .buf_write(link.buf_write), .buf_read(link.buf_read), .wdata(link.wdata), .rdata(link.rdata),
      .rvalid(link.rvalid), .software_init(link.software_init), .prescale_hi(link.prescale_hi));
   // 50 ns clock
   always #25 clock = ~clock;
   // hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   // one host command, returns read word and refusal
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d,
                       output logic [15:0] rd, output logic rf);
      rd = 'x;
      rf = 1'b0;
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = d;
      @(posedge clock);
      #1 cmd_valid = 1'b0;
      for (int i = 0; i < 10; i++) begin
         if (cmd_refused_q) rf = 1'b1;
         if (resp_valid_q) rd = resp_data_q;
         if (cmd_ready) break;
         @(posedge clock);
         #1;
      end
      // one spare edge so the next command never re-raises cmd_valid in this time step
      @(posedge clock);
      #1;
   endtask : xfer
   task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic exp_rf);
      logic [15:0] rd;
      logic        rf;
      xfer(1'b1, a, d, rd, rf);
      chk("refused", 32'(exp_rf), 32'(rf));
   endtask : wr
   task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] rd;
      logic        rf;
      xfer(1'b0, a, 16'h0000, rd, rf);
      chk("word", 32'(exp), 32'(rd));
   endtask : rdc
   task automatic set_init(input logic v);
      init_request = v;
      repeat (2) @(posedge clock);
      #1;
   endtask : set_init
   // f = {centre 15, extended, masking, media test}
   task automatic cand(input logic [3:0] f, input logic [28:0] a, input logic re, input logic [28:0] id,
                       input logic [7:0] b0, input logic exp);
      {cand_last_centre, cand_ext, cand_mask_en, cand_media_en} = f;
      cand_arb = a;
      rx_ext = re;
      rx_id = id;
      rx_byte0 = b0;
      cand_valid = 1'b1;
      @(posedge clock);
      #1 cand_valid = 1'b0;
      chk("accept_valid", 32'h1, 32'(accept_valid_q));
      chk("accept", 32'(exp), 32'(accept_q));
      // spare edge so cand_valid is not raised again in this time step
      @(posedge clock);
      #1;
   endtask : cand
   task automatic wait_strobe(output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (!bit_strobe_q && n < 400);
   endtask : wait_strobe
   task automatic bit_time(input logic [15:0] w, input int exp, input logic rxv);
      int n;
      wr(7'h02, w, 1'b0);
      rx_pin = rxv;
      repeat (4) wait_strobe(n);
      chk("bit_cycles", exp, n);
      chk("bit_value", 32'(rxv), 32'(bit_value_q));
   endtask : bit_time
   // reset values and zero masks
   task automatic s_reset;
      for (int a = 0; a < 8; a++) rdc(a[6:0], WORD_RESET);
      cand(4'h6, 29'h0, 1'b1, 29'h1FFFFFFF, 8'h00, 1'b1);
      cand(4'hE, 29'h0, 1'b1, 29'h1FFFFFFF, 8'h00, 1'b1);
      wr(7'h04, 16'hFFFF, 1'b1);
      rdc(7'h04, 16'h0000);
   endtask : s_reset
   // fill every word except the timing word, unused bits stay zero
   task automatic s_fill;
      set_init(1'b1);
      for (int a = 0; a < 8; a++) begin
         if (a != 2) begin
            wr(a[6:0], 16'hFFFF, 1'b0);
            rdc(a[6:0], (a == 3) ? STD_MASK_USED : (a == 5 || a == 7) ? LOW29_USED : FULL_USED);
         end
      end
      wr(7'h40, 16'hFFFF, 1'b0);
      rdc(7'h40, 16'h0000);
      set_init(1'b0);
      wr(7'h03, 16'h0000, 1'b1);
      rdc(7'h03, STD_MASK_USED);
   endtask : s_fill
   // acceptance test under programmed masks
   task automatic s_filter;
      set_init(1'b1);
      wr(7'h00, 16'hA50F, 1'b0);
      rx_byte1 = 8'h5A;
      wr(7'h01, 16'h5A03, 1'b0);
      wr(7'h03, 16'h00FF, 1'b0);
      wr(7'h04, 16'h00FF, 1'b0);
      wr(7'h05, 16'h0000, 1'b0);
      wr(7'h06, 16'h0000, 1'b0);
      wr(7'h07, 16'h0800, 1'b0);
      cand(4'h2, 29'h0, 1'b0, 29'h00040000, 8'h00, 1'b1);
      cand(4'h2, 29'h0, 1'b0, 29'h00200000, 8'h00, 1'b0);
      cand(4'h0, 29'h0, 1'b0, 29'h00040000, 8'h00, 1'b0);
      cand(4'h2, 29'h0, 1'b1, 29'h0, 8'h00, 1'b0);
      cand(4'h6, 29'h0, 1'b1, 29'h00000001, 8'h00, 1'b1);
      cand(4'h6, 29'h0, 1'b1, 29'h00200000, 8'h00, 1'b0);
      cand(4'hE, 29'h0, 1'b1, 29'h00000001, 8'h00, 1'b0);
      cand(4'hE, 29'h0, 1'b1, 29'h00200000, 8'h00, 1'b1);
      cand(4'hA, 29'h0, 1'b0, 29'h00000001, 8'h00, 1'b1);
      cand(4'h1, 29'h0, 1'b0, 29'h0, 8'h35, 1'b1);
      cand(4'h1, 29'h0, 1'b0, 29'h0, 8'hA4, 1'b0);
      cand(4'h0, 29'h0, 1'b0, 29'h0, 8'hA4, 1'b1);
      rx_byte1 = 8'h59;
      cand(4'h1, 29'h0, 1'b0, 29'h0, 8'h35, 1'b0);
   endtask : s_filter
   // bit timing: refusals, then single and triple sampling
   task automatic s_timing;
      wr(7'h02, 16'h0101, 1'b1);
      wr(7'h02, 16'h1001, 1'b1);
      wr(7'h02, 16'h9102, 1'b1);
      bit_time(16'h1101, 10, 1'b0);
      bit_time(16'hA303, 34, 1'b1);
   endtask : s_timing
   // main sequence
   initial begin
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
      s_reset();
      s_fill();
      s_filter();
      s_timing();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
